// File: dac_ctrl.sv
`timescale 1ns/1ps
module dac_ctrl
  import dac_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int REFRESH_CYCLES = REFRESH_INTERVAL_CYC,
  parameter bit INIT_WITH_CBR = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire dac_req_t i_req,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic o_rdata,
  output logic o_init_done,
  output dac_pins_t o_pins,
  input wire logic i_data_out
);
  localparam int T_RP = ns2cyc(ROW_PRECHARGE_NS);
  localparam int T_RAS = ns2cyc(ROW_PULSE_NS);
  localparam int T_RCD = ns2cyc(ROW_TO_COL_NS);
  localparam int T_RAH = ns2cyc(ROW_ADDR_HOLD_NS);
  localparam int T_CAS = ns2cyc(COL_PULSE_NS);
  localparam int T_ACC = ns2cyc(ACCESS_NS);
  localparam int T_RWL = ns2cyc(WRITE_TO_ROW_LEAD_NS);
  localparam int T_CP = ns2cyc(PAGE_COL_PRECHARGE_NS);
  localparam int T_CWD = ns2cyc(COLSTROBE_TO_WRITE_NS);
  localparam int T_CSR = ns2cyc(CBR_SETUP_NS);
  localparam int CNT_W = 32;

  // refuse counts that the pacing logic cannot serve
  if (POWERUP_CYCLES < 1 || REFRESH_CYCLES < 64) begin
    $error("dac_ctrl: counts too small");
  end

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_INIT = 4'h1,
    ST_IDLE = 4'h2,
    ST_ROW = 4'h3,
    ST_COL = 4'h4,
    ST_WRITE = 4'h5,
    ST_HOLD = 4'h6,
    ST_CBR_SETUP = 4'h7,
    ST_CBR_ROW = 4'h8,
    ST_TEST_PRE = 4'h9,
    ST_TEST_COL = 4'hA,
    ST_PRECHARGE = 4'hB,
    ST_HIDDEN = 4'hC
  } dac_state_t;

  dac_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] ref_ff, nxt_ref;
  logic [3:0] init_ff, nxt_init;
  logic ref_due_ff, nxt_ref_due;
  dac_req_t req_ff, nxt_req;
  dac_pins_t pins_ff, nxt_pins;
  logic rvalid_ff, nxt_rvalid;
  logic rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic dout_s1_ff, dout_s2_ff;
  logic [ROW_W-1:0] init_row_ff, nxt_init_row;

  // the memory's output pin is asynchronous to us
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      dout_s1_ff <= 1'b0;
      dout_s2_ff <= 1'b0;
    end else begin
      dout_s1_ff <= i_data_out;
      dout_s2_ff <= dout_s1_ff;
    end
  end

  assign o_req_ready = (state_ff == ST_IDLE) && !ref_due_ff && done_ff;
  assign o_rdata_valid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_init_done = done_ff;
  assign o_pins = pins_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_ref = ref_ff + 1'b1;
    nxt_ref_due = ref_due_ff;
    nxt_init = init_ff;
    nxt_req = req_ff;
    nxt_pins = pins_ff;
    nxt_rvalid = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_done = done_ff;
    nxt_init_row = init_row_ff;
    unique case (state_ff)
      ST_POWERUP: begin
        nxt_pins.row_strobe_n = 1'b1;
        nxt_pins.col_strobe_n = 1'b1;
        if (cnt_ff >= CNT_W'(POWERUP_CYCLES - 1)) begin
          nxt_state = ST_PRECHARGE;
          nxt_cnt = '0;
        end
      end
      ST_PRECHARGE: begin
        nxt_pins.row_strobe_n = 1'b1;
        nxt_pins.write_n = 1'b1;
        // hidden refresh keeps column low through row precharge
        if (req_ff.op != DAC_OP_HIDDEN_REFRESH || !done_ff) begin
          nxt_pins.col_strobe_n = 1'b1;
        end
        if (cnt_ff >= CNT_W'(T_RP - 1)) begin
          nxt_cnt = '0;
          if (!done_ff && init_ff == 4'(INIT_CYCLES)) begin
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
          end else if (!done_ff) begin
            nxt_state = ST_INIT;
          end else if (req_ff.op == DAC_OP_HIDDEN_REFRESH) begin
            nxt_state = ST_HIDDEN;
          end else begin
            nxt_pins.col_strobe_n = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_INIT: begin
        nxt_cnt = '0;
        nxt_init = init_ff + 4'h1;
        if (INIT_WITH_CBR) begin
          nxt_pins.col_strobe_n = 1'b0;
          nxt_state = ST_CBR_SETUP;
        end else begin
          nxt_pins.multiplexed_address_pins = init_row_ff;
          nxt_init_row = init_row_ff + 1'b1;
          nxt_pins.row_strobe_n = 1'b0;
          nxt_state = ST_CBR_ROW;
        end
      end
      ST_IDLE: begin
        nxt_cnt = '0;
        if (ref_due_ff) begin
          nxt_ref_due = 1'b0;
          nxt_req.op = DAC_OP_CBR_REFRESH;
          nxt_pins.col_strobe_n = 1'b0;
          nxt_state = ST_CBR_SETUP;
        end else if (i_req_valid) begin
          nxt_req = i_req;
          if (i_req.op == DAC_OP_CBR_REFRESH
              || i_req.op == DAC_OP_COUNTER_TEST) begin
            nxt_pins.col_strobe_n = 1'b0;
            nxt_state = ST_CBR_SETUP;
          end else if (i_req.op == DAC_OP_HIDDEN_REFRESH) begin
            // hidden refresh rides on a read of the given address
            nxt_pins.multiplexed_address_pins = i_req.row;
            nxt_pins.write_n = 1'b1;
            nxt_pins.row_strobe_n = 1'b0;
            nxt_state = ST_ROW;
          end else begin
            nxt_pins.multiplexed_address_pins = i_req.row;
            nxt_pins.write_n = (i_req.op != DAC_OP_WRITE);
            nxt_pins.data_in = i_req.wdata;
            nxt_pins.row_strobe_n = 1'b0;
            nxt_state = (i_req.op == DAC_OP_ROW_REFRESH) ? ST_CBR_ROW
                                                          : ST_ROW;
          end
        end
      end
      ST_ROW: begin
        if (cnt_ff == CNT_W'(T_RAH - 1)) begin
          nxt_pins.multiplexed_address_pins = req_ff.col;
        end
        // strobe delay within the maximum keeps row access governing
        if (cnt_ff >= CNT_W'(T_RCD - 1)) begin
          nxt_pins.col_strobe_n = 1'b0;
          nxt_cnt = '0;
          nxt_state = ST_COL;
        end
      end
      ST_COL: begin
        // sample once the slowest access has elapsed
        if (cnt_ff >= CNT_W'(T_ACC + 1)) begin
          nxt_cnt = '0;
          if (req_ff.op == DAC_OP_WRITE) begin
            nxt_state = ST_HOLD;
          end else begin
            nxt_rdata = dout_s2_ff;
            nxt_rvalid = (req_ff.op != DAC_OP_RMW);
            if (req_ff.op == DAC_OP_RMW
                || (req_ff.op == DAC_OP_COUNTER_TEST && req_ff.invert)) begin
              nxt_pins.data_in = req_ff.invert ? ~dout_s2_ff
                                               : req_ff.wdata;
              nxt_rvalid = 1'b1;
              nxt_state = ST_WRITE;
            end else begin
              nxt_state = ST_HOLD;
            end
          end
        end
      end
      ST_WRITE: begin
        // data settled one cycle before the late write edge
        nxt_pins.write_n = 1'b0;
        if (cnt_ff >= CNT_W'(T_CWD)) begin
          nxt_cnt = '0;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // write stays low for the lead before the strobes rise; hidden refresh raises only the row strobe
        if (cnt_ff >= CNT_W'(T_RWL)) begin
          if (req_ff.op == DAC_OP_HIDDEN_REFRESH) begin
            nxt_pins.row_strobe_n = 1'b1;
          end else begin
            nxt_pins.col_strobe_n = 1'b1;
            nxt_pins.row_strobe_n = 1'b1;
            nxt_pins.write_n = 1'b1;
          end
          nxt_cnt = '0;
          nxt_state = ST_PRECHARGE;
        end
      end
      ST_CBR_SETUP: begin
        if (cnt_ff >= CNT_W'(T_CSR - 1)) begin
          nxt_pins.row_strobe_n = 1'b0;
          nxt_cnt = '0;
          nxt_state = (req_ff.op == DAC_OP_COUNTER_TEST && done_ff)
                      ? ST_TEST_PRE : ST_CBR_ROW;
        end
      end
      ST_CBR_ROW: begin
        // refresh-only cycles leave the output tri-stated
        if (cnt_ff >= CNT_W'(T_RAS - 1)) begin
          nxt_pins.row_strobe_n = 1'b1;
          nxt_pins.col_strobe_n = 1'b1;
          nxt_cnt = '0;
          nxt_state = ST_PRECHARGE;
        end
      end
      ST_TEST_PRE: begin
        if (cnt_ff == CNT_W'(T_CAS)) begin
          nxt_pins.col_strobe_n = 1'b1;
          nxt_pins.multiplexed_address_pins = req_ff.col;
          nxt_pins.write_n = 1'b1;
        end
        if (cnt_ff >= CNT_W'(T_CAS + T_CP)) begin
          nxt_pins.col_strobe_n = 1'b0;
          nxt_cnt = '0;
          nxt_state = ST_TEST_COL;
        end
      end
      ST_TEST_COL: begin
        nxt_state = ST_COL;
        nxt_cnt = '0;
        if (!req_ff.invert) begin
          nxt_pins.write_n = 1'b1;
        end
      end
      ST_HIDDEN: begin
        // column low across row precharge makes it column-first
        nxt_pins.row_strobe_n = 1'b0;
        nxt_req.op = DAC_OP_CBR_REFRESH;
        nxt_cnt = '0;
        nxt_state = ST_CBR_ROW;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // refresh pacing: 512 row refreshes per period
    // after the case, so a new due beats a same-cycle clear
    if (ref_ff >= CNT_W'(REFRESH_CYCLES - 1)) begin
      nxt_ref = '0;
      nxt_ref_due = done_ff;
    end
    // fast page is used only by the counter test, so every other access refreshes its row
    nxt_req.invert = nxt_req.invert;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_ff <= ST_POWERUP;
      cnt_ff <= '0;
      ref_ff <= '0;
      ref_due_ff <= 1'b0;
      init_ff <= 4'h0;
      req_ff <= '0;
      pins_ff <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                   write_n: 1'b1, default: '0};
      rvalid_ff <= 1'b0;
      rdata_ff <= 1'b0;
      done_ff <= 1'b0;
      init_row_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ref_ff <= nxt_ref;
      ref_due_ff <= nxt_ref_due;
      init_ff <= nxt_init;
      req_ff <= nxt_req;
      pins_ff <= nxt_pins;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
      init_row_ff <= nxt_init_row;
    end
  end
endmodule

// File: dac_pkg.sv
package dac_pkg;
  // pin-level and timing constants of the one-bit dynamic memory
  localparam int ADDR_W = 10;
  localparam int ROW_W = 10;
  localparam int ROWS = 512;
  localparam int CLK_NS = 10;
  localparam int CLK_MHZ = 100;
  // least times in ns, rounded up to cycles
  localparam int POWERUP_US = 200;
  localparam int INIT_CYCLES = 8;
  localparam int ROW_PRECHARGE_NS = 70;
  localparam int ROW_PULSE_NS = 100;
  localparam int ROW_TO_COL_NS = 25;
  localparam int ROW_ADDR_HOLD_NS = 15;
  localparam int COL_PULSE_NS = 25;
  localparam int ACCESS_NS = 100;
  localparam int WRITE_TO_ROW_LEAD_NS = 50;
  localparam int PAGE_COL_PRECHARGE_NS = 10;
  localparam int PAGE_RMW_CYCLE_NS = 62;
  localparam int COLSTROBE_TO_WRITE_NS = 25;
  localparam int REFRESH_PERIOD_US = 8200;
  localparam int CBR_SETUP_NS = 20;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  // longest time rounds down; spread 512 refreshes across the period
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_US * CLK_MHZ) / ROWS;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  typedef enum logic [2:0] {
    DAC_OP_READ = 3'h0,
    DAC_OP_WRITE = 3'h1,
    DAC_OP_RMW = 3'h2,
    DAC_OP_ROW_REFRESH = 3'h3,
    DAC_OP_CBR_REFRESH = 3'h4,
    DAC_OP_HIDDEN_REFRESH = 3'h5,
    DAC_OP_COUNTER_TEST = 3'h6
  } dac_op_t;

  typedef struct packed {
    dac_op_t op;
    logic [ROW_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic wdata;
    logic invert;
  } dac_req_t;

  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_n;
    logic [ADDR_W-1:0] multiplexed_address_pins;
    logic data_in;
  } dac_pins_t;
endpackage

// File: dac_ctrl_assertions.sv
`timescale 1ns/1ps
module dac_ctrl_assertions
  import dac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire dac_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rdata_valid,
  input wire logic o_rdata,
  input wire logic o_init_done,
  input wire dac_pins_t o_pins,
  input wire logic i_data_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_take(dac_op_t op);
    i_req_valid && o_req_ready && i_req.op == op;
  endsequence
  a_ready_after_init: assert property (
    !o_init_done |-> !o_req_ready && o_pins.write_n)
    else $error("ready or write before init");
  a_row_only_colhigh: assert property (
    s_take(DAC_OP_ROW_REFRESH) |=>
      (o_pins.col_strobe_n && !o_rdata_valid) [*8])
    else $error("row-only refresh moved column strobe");
  a_read_we_high: assert property (
    s_take(DAC_OP_READ) |-> ##2 o_pins.write_n [*8])
    else $error("write enable low in read");
  a_early_write: assert property (
    s_take(DAC_OP_WRITE) |-> ##2 !o_pins.write_n [*3])
    else $error("write enable not low early");
  a_rmw_late_we: assert property (
    s_take(DAC_OP_RMW) |=> o_pins.write_n [*8])
    else $error("rmw write enable too early");
  a_row_before_col: assert property (
    $fell(o_pins.col_strobe_n) && !o_pins.row_strobe_n |->
      !$past(o_pins.row_strobe_n, 2))
    else $error("column strobe too soon after row");
  a_cbr_col_first: assert property (
    $fell(o_pins.row_strobe_n) && !o_pins.col_strobe_n |->
      !$past(o_pins.col_strobe_n)) else $error("column setup missing");
  a_read_answer: assert property (
    s_take(DAC_OP_READ) |-> ##[8:60] o_rdata_valid)
    else $error("read data not returned");
  a_write_lead: assert property (
    $rose(o_pins.row_strobe_n) && !$past(o_pins.write_n) |->
      !$past(o_pins.write_n, 5)) else $error("write lead too short");
endmodule

bind dac_ctrl dac_ctrl_assertions chk_u (.*);

// File: dac_mem_model.sv
`timescale 1ns/1ps
module dac_mem_model
  import dac_pkg::*;
#(
  parameter int ACC_NS = 20
) (
  input wire dac_pins_t i_pins,
  output logic o_dout
);
  bit mem [int];
  logic [ROW_W-1:0] row_q = '0;
  logic [ROW_W-1:0] cnt_q = '0;
  int addr_q = 0;
  initial o_dout = 1'b0;
  // counter row keeps the top bit set for a following counter test
  always @(negedge i_pins.row_strobe_n) begin
    if (!i_pins.col_strobe_n) begin
      row_q = {1'b1, cnt_q[8:0]};
      cnt_q = cnt_q + 1'b1;
    end else begin
      row_q = i_pins.multiplexed_address_pins;
    end
  end
  always @(negedge i_pins.col_strobe_n) begin
    if (!i_pins.row_strobe_n) begin
      addr_q = {row_q, i_pins.multiplexed_address_pins};
      if (!i_pins.write_n)
        mem[addr_q] = i_pins.data_in;
      else
        o_dout <= #ACC_NS mem[addr_q];
    end
  end
  always @(negedge i_pins.write_n)
    if (!i_pins.row_strobe_n && !i_pins.col_strobe_n)
      mem[addr_q] = i_pins.data_in;
  // released output flips so a stale bit never reads as good
  always @(posedge i_pins.col_strobe_n) o_dout <= ~o_dout;
endmodule

// File: dac_ctrl_tb.sv
`timescale 1ns/1ps
module dac_ctrl_tb;
  import dac_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req_valid = 1'b0;
  dac_req_t i_req = '0;
  logic o_req_ready, o_rdata_valid, o_rdata, o_init_done, i_data_out;
  dac_pins_t o_pins;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_ronly = 0;
  int n_cbr = 0;
  logic [9:0] r [4] = '{10'h000, 10'h1FF, 10'h155, 10'h0AA};
  logic [9:0] c [4] = '{10'h000, 10'h3FF, 10'h2AA, 10'h155};
  dac_ctrl #(.POWERUP_CYCLES(50), .REFRESH_CYCLES(200)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
    .o_init_done(o_init_done), .o_pins(o_pins), .i_data_out(i_data_out));
  dac_mem_model #(.ACC_NS(50)) mem_u (.i_pins(o_pins), .o_dout(i_data_out));
  initial forever #5 i_clk = ~i_clk;
  always @(negedge o_pins.row_strobe_n)
    if (o_pins.col_strobe_n) n_ronly++;
    else n_cbr++;
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %0h got %0h", name, exp, got);
    end
  endtask
  task automatic req(dac_op_t op, logic [9:0] ra, logic [9:0] ca,
                     logic d, logic inv);
    int n = 0;
    @(posedge i_clk);
    #1;
    i_req = '{op, ra, ca, d, inv};
    i_req_valid = 1'b1;
    // ready comes from flops, so what shows now holds at the next edge
    while (o_req_ready !== 1'b1 && n < 500) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    #1;
    i_req_valid = 1'b0;
    check("request taken", 1, n < 500);
  endtask
  task automatic rd(string name, logic exp);
    int n = 0;
    while (o_rdata_valid !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check({name, " valid"}, 1, o_rdata_valid);
    check(name, exp, o_rdata);
  endtask
  task automatic t_init();
    int n = 0;
    while (o_init_done !== 1'b1 && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("init done", 1, o_init_done);
    check("row-only init count", 8, n_ronly);
    $display("init test done");
  endtask
  task automatic t_wr();
    for (int i = 0; i < 4; i++)
      req(DAC_OP_WRITE, r[i], c[i], i[0], 1'b0);
    for (int i = 0; i < 4; i++) begin
      req(DAC_OP_READ, r[i], c[i], !i[0], 1'b0);
      rd("read data", i[0]);
      check("stored cell", i[0], mem_u.mem[{r[i], c[i]}]);
    end
    $display("write read test done");
  endtask
  task automatic t_rmw();
    req(DAC_OP_RMW, r[1], c[1], 1'b1, 1'b1);
    rd("rmw old data", 1'b1);
    req(DAC_OP_READ, r[1], c[1], 1'b0, 1'b0);
    rd("rmw new data", 1'b0);
    $display("rmw test done");
  endtask
  task automatic t_refresh();
    int k = n_cbr;
    req(DAC_OP_ROW_REFRESH, r[2], c[0], 1'b1, 1'b0);
    req(DAC_OP_CBR_REFRESH, r[0], c[0], 1'b1, 1'b0);
    req(DAC_OP_HIDDEN_REFRESH, r[3], c[3], 1'b0, 1'b0);
    rd("hidden read data", 1'b1);
    req(DAC_OP_READ, r[2], c[2], 1'b1, 1'b0);
    rd("after refresh", 1'b0);
    check("column first refreshes", 1, n_cbr - k >= 2);
    $display("refresh test done");
  endtask
  task automatic t_ctest();
    req(DAC_OP_COUNTER_TEST, r[0], c[2], 1'b0, 1'b1);
    rd("counter test data", 1'b0);
    check("test row top bit", 1, mem_u.addr_q[19]);
    check("test column", c[2], mem_u.addr_q[9:0]);
    // the test write lands one cycle after the read pulse
    req(DAC_OP_READ, mem_u.addr_q[19:10], c[2], 1'b0, 1'b0);
    check("test write", 1, mem_u.mem[mem_u.addr_q]);
    rd("read after test", 1'b1);
    $display("counter test done");
  endtask
  task automatic t_auto();
    int k = n_cbr;
    repeat (600) @(posedge i_clk);
    check("periodic refreshes", 1, n_cbr - k >= 2);
    $display("auto refresh test done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    check("strobes in reset", 2'h3,
          {o_pins.row_strobe_n, o_pins.col_strobe_n});
    i_reset_n = 1'b1;
    t_init();
    t_wr();
    t_rmw();
    t_refresh();
    t_ctest();
    t_auto();
    tally_and_finish();
  end
endmodule
